// *** src/mtc_regs.vh ***
// Register offsets, field positions and reset values of the MAC timer config block
// Behaviour
// RQ1: Compare event sets flag bit 7 of timer_config.
// RQ2: Period event sets flag bit 6 of timer_config.
// RQ3: Overflow-count compare event sets flag bit 5 of timer_config.
// RQ4: Flags clear only when written zero; writing one keeps them.
// RQ5: Software always writes zero to reserved bit 2.
// RQ6: Bit 3 picks compared timer byte: zero high byte, one low byte.
// RQ7: Bit 1 resets to one; one aligns start/stop to slow edge and reloads.
// RQ8: Writing run bit zero stops timer, one starts it.
// RQ9: Reading run bit returns actual running state.
// RQ10: With alignment, run status changes only when aligned start/stop happens.
// RQ11: High value read returns high byte latched at last low value read.
// RQ12: High value write while running loads delta; counting halts that many cycles.
// RQ13: Delta low byte comes from last value written to low register.
// RQ14: High value write while idle loads byte into timer high byte.
// RQ15: Low register write takes effect only when high register is written.
// RQ16: Delta counter decrements at timer rate, stops at zero until rewritten.
// RQ17: Flags set regardless of mask; interrupt only when mask bit is one.
// RQ18: Bit 4 reads zero; writes to it have no effect.
`ifndef MTC_REGS_VH
`define MTC_REGS_VH

`define MTC_ADDR_VALUE_LOW   8'hA6
`define MTC_ADDR_VALUE_HIGH  8'hA7
`define MTC_ADDR_CONFIG      8'hC3
`define MTC_ADDR_COMPARE     8'h94

`define MTC_BIT_CMP_FLAG     7
`define MTC_BIT_PER_FLAG     6
`define MTC_BIT_OFC_FLAG     5
`define MTC_BIT_UNUSED       4
`define MTC_BIT_BYTE_SEL     3
`define MTC_BIT_RESERVED     2
`define MTC_BIT_SYNC         1
`define MTC_BIT_RUN          0

`define MTC_CONFIG_RESET     8'h02
`define MTC_VALUE_RESET      8'h00
`define MTC_PERIOD_RESET     16'h0000

`endif

// *** src/mtc_flag.v ***
// One sticky event flag, set by hardware, cleared by writing zero
`timescale 1ns/10ps
module mtc_flag (
    input  wire clk_sys,
    input  wire nrst,
    input  wire set_event,
    input  wire wr_en,
    input  wire wr_bit,
    output reg  flag
);
    // Set wins over a same-cycle clear so no event is lost
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (set_event) begin
            flag <= 1'b1;
        end else if (wr_en && !wr_bit) begin
            flag <= 1'b0; // RQ4
        end
    end
endmodule

// *** src/mtc_sync_edge.v ***
// Rising-edge detect of the slow 32.768 kHz tick after two-stage synchronisation
`timescale 1ns/10ps
module mtc_sync_edge (
    input  wire clk_sys,
    input  wire nrst,
    input  wire slow_clk,
    output wire slow_rise
);
    reg meta;
    reg stable;
    reg last;

    // First stage feeds only the second stage
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            last   <= 1'b0;
        end else begin
            meta   <= slow_clk;
            stable <= meta;
            last   <= stable;
        end
    end

    assign slow_rise = stable & ~last;
endmodule

// *** src/mtc_top.v ***
// MAC timer configuration, run control and timer value access logic
`timescale 1ns/10ps
`include "mtc_regs.vh"
module mtc_top (
    input  wire       clk_sys,
    input  wire       nrst,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    input  wire       slow_clk,
    input  wire [15:0] period,
    input  wire       ovf_cmp_event,
    input  wire       reload_valid,
    input  wire [15:0] reload_value,
    input  wire [2:0] irq_mask,
    output wire       irq,
    output reg  [15:0] timer_count,
    output wire       timer_running,
    output wire       compare_pulse,
    output wire       period_pulse
);
    ////////////////////////////////////////////////////////////////////////
    // Run states
    localparam [2:0] ST_IDLE     = 3'b001;
    localparam [2:0] ST_RUN      = 3'b010;
    localparam [2:0] ST_RELOAD   = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         run_request;
    reg         byte_sel;
    reg         reserved_bit;
    reg         sync_en;
    reg  [7:0]  compare_value;
    reg  [7:0]  low_written;
    reg  [7:0]  high_latched;
    reg  [15:0] delta_count;
    reg         cmp_match_last;
    wire        slow_rise;
    wire        cmp_flag;
    wire        per_flag;
    wire        ofc_flag;
    wire        cfg_wr;
    wire        low_rd;
    wire        high_wr;
    wire        cmp_wr;
    wire        low_wr;
    wire        counting;
    wire        at_top;
    wire        cmp_match;
    wire [7:0]  cmp_source;
    wire [7:0]  config_read;

    assign cfg_wr  = sfr_wr && (sfr_addr == `MTC_ADDR_CONFIG);
    assign high_wr = sfr_wr && (sfr_addr == `MTC_ADDR_VALUE_HIGH);
    assign low_wr  = sfr_wr && (sfr_addr == `MTC_ADDR_VALUE_LOW);
    assign cmp_wr  = sfr_wr && (sfr_addr == `MTC_ADDR_COMPARE);
    assign low_rd  = sfr_rd && (sfr_addr == `MTC_ADDR_VALUE_LOW);

    ////////////////////////////////////////////////////////////////////////
    // Slow edge detection
    mtc_sync_edge u_edge (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .slow_clk  (slow_clk),
        .slow_rise (slow_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control bits; bit 4 has no storage, bit 2 kept as written
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_request   <= 1'b0;
            byte_sel      <= 1'b0;
            reserved_bit  <= 1'b0;
            sync_en       <= 1'b1; // RQ7
            compare_value <= `MTC_VALUE_RESET;
        end else begin
            if (cfg_wr) begin
                run_request  <= sfr_wdata[`MTC_BIT_RUN]; // RQ8
                byte_sel     <= sfr_wdata[`MTC_BIT_BYTE_SEL]; // RQ6
                reserved_bit <= sfr_wdata[`MTC_BIT_RESERVED]; // RQ5
                sync_en      <= sfr_wdata[`MTC_BIT_SYNC]; // RQ7
            end
            if (cmp_wr) begin
                compare_value <= sfr_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run state machine: immediate or aligned to slow edge
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (run_request && (!sync_en || slow_rise)) begin
                    next_state = sync_en ? ST_RELOAD : ST_RUN; // RQ7 RQ10
                end
            end
            ST_RELOAD: begin
                // Waits for the reload arithmetic outside this block
                if (!run_request) begin
                    next_state = ST_IDLE;
                end else if (reload_valid) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_request && (!sync_en || slow_rise)) begin
                    next_state = ST_IDLE; // RQ8 RQ10
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign timer_running = (state == ST_RUN); // RQ9

    ////////////////////////////////////////////////////////////////////////
    // Delta halt counter and the 16-bit count
    assign counting = timer_running && (delta_count == 16'h0000);
    assign at_top   = (timer_count >= period) && (period != `MTC_PERIOD_RESET);

    // Low byte held until the high byte write commits it
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_written <= `MTC_VALUE_RESET;
        end else if (low_wr) begin
            low_written <= sfr_wdata; // RQ15
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            delta_count <= 16'h0000;
        end else if (high_wr && timer_running) begin
            delta_count <= {sfr_wdata, low_written}; // RQ12 RQ13
        end else if (timer_running && (delta_count != 16'h0000)) begin
            delta_count <= delta_count - 16'h0001; // RQ16
        end
    end

    // Halted cycles are simply not counted, stretching the period
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_count <= 16'h0000;
        end else if (state == ST_RELOAD && reload_valid) begin
            timer_count <= reload_value; // RQ7
        end else if (high_wr && !timer_running) begin
            timer_count <= {sfr_wdata, low_written}; // RQ14 RQ15
        end else if (counting) begin
            if (at_top) begin
                timer_count <= 16'h0000;
            end else begin
                timer_count <= timer_count + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare on the selected byte; event on entry into match
    assign cmp_source = byte_sel ? timer_count[7:0] : timer_count[15:8]; // RQ6
    assign cmp_match  = timer_running && (cmp_source == compare_value);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmp_match_last <= 1'b0;
        end else begin
            cmp_match_last <= cmp_match;
        end
    end

    assign compare_pulse = cmp_match && !cmp_match_last;
    assign period_pulse  = counting && at_top;

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags
    mtc_flag u_cmp_flag (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .set_event (compare_pulse), // RQ1
        .wr_en     (cfg_wr),
        .wr_bit    (sfr_wdata[`MTC_BIT_CMP_FLAG]),
        .flag      (cmp_flag)
    );

    mtc_flag u_per_flag (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .set_event (period_pulse), // RQ2
        .wr_en     (cfg_wr),
        .wr_bit    (sfr_wdata[`MTC_BIT_PER_FLAG]),
        .flag      (per_flag)
    );

    mtc_flag u_ofc_flag (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .set_event (ovf_cmp_event), // RQ3
        .wr_en     (cfg_wr),
        .wr_bit    (sfr_wdata[`MTC_BIT_OFC_FLAG]),
        .flag      (ofc_flag)
    );

    // Mask gates the request only, never the flag
    assign irq = (cmp_flag & irq_mask[2]) | (per_flag & irq_mask[1]) | (ofc_flag & irq_mask[0]); // RQ17

    ////////////////////////////////////////////////////////////////////////
    // Read path; high byte captured when low byte is read
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            high_latched <= `MTC_VALUE_RESET;
        end else if (low_rd) begin
            high_latched <= timer_count[15:8]; // RQ11
        end
    end

    assign config_read = {cmp_flag, per_flag, ofc_flag, 1'b0, byte_sel, reserved_bit, sync_en,
                          timer_running}; // RQ18 RQ9

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `MTC_ADDR_CONFIG:     sfr_rdata <= config_read;
                `MTC_ADDR_VALUE_LOW:  sfr_rdata <= timer_count[7:0];
                `MTC_ADDR_VALUE_HIGH: sfr_rdata <= high_latched; // RQ11
                `MTC_ADDR_COMPARE:    sfr_rdata <= compare_value;
                default:              sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// *** testbench/mtc_chk.sv ***
// Checker of run control, flag, value access and delta relations at the MAC timer block ports
`timescale 1ns/10ps
`include "mtc_regs.vh"
module mtc_chk (
    input wire        clk_sys,
    input wire        nrst,
    input wire [7:0]  sfr_addr,
    input wire        sfr_wr,
    input wire        sfr_rd,
    input wire [7:0]  sfr_wdata,
    input wire [7:0]  sfr_rdata,
    input wire        ovf_cmp_event,
    input wire        reload_valid,
    input wire [2:0]  irq_mask,
    input wire        irq,
    input wire [15:0] timer_count,
    input wire        timer_running,
    input wire        compare_pulse,
    input wire        period_pulse
);
    reg  [7:0] low_q;
    wire [7:0] cnt_low = timer_count[7:0];
    wire       wr_hi   = sfr_wr && sfr_addr == `MTC_ADDR_VALUE_HIGH;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the last low byte written; the delta low half comes from here
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) low_q <= 8'h00;
        else if (sfr_wr && sfr_addr == `MTC_ADDR_VALUE_LOW) low_q <= sfr_wdata;
    end
    sequence s_cfg_wr;
        sfr_wr && sfr_addr == `MTC_ADDR_CONFIG;
    endsequence
    sequence s_hi_wr;
        wr_hi;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_cmp_irq: assert property (compare_pulse && irq_mask[2] |=> irq) else $error("compare left irq low");
    a_per_irq: assert property (period_pulse && irq_mask[1] |=> irq) else $error("period left irq low");
    a_ofc_irq: assert property (ovf_cmp_event && irq_mask[0] |=> irq) else $error("ovf cmp left irq low");
    a_mask_blocks_irq: assert property (irq_mask == 3'h0 |-> !irq) else $error("irq while masked");
    // A flag only drops through a config write, so irq only falls then or on a mask change
    a_flag_sticky: assert property ($fell(irq) |-> $changed(irq_mask) || $past(sfr_wr && sfr_addr == `MTC_ADDR_CONFIG))
        else $error("irq fell without clear");
    // Run bit lands on the write edge, the state register follows one edge later
    a_imm_start: assert property (s_cfg_wr ##0 sfr_wdata[1:0] == 2'h1 |=> ##1 timer_running)
        else $error("immediate start missed");
    a_imm_stop: assert property (s_cfg_wr ##0 sfr_wdata[1:0] == 2'h0 |=> ##1 !timer_running)
        else $error("immediate stop missed");
    a_sync_defer: assert property (s_cfg_wr ##0 (sfr_wdata[1:0] == 2'h3 && !timer_running) |=> ##1 !timer_running)
        else $error("aligned start was immediate");
    a_low_read: assert property (sfr_rd && sfr_addr == `MTC_ADDR_VALUE_LOW |=> sfr_rdata == $past(cnt_low))
        else $error("low read wrong");
    a_idle_hold: assert property (!timer_running && !reload_valid && !wr_hi
        && !(sfr_wr && sfr_addr == `MTC_ADDR_CONFIG) |=> $stable(timer_count)) else $error("idle count moved");
    a_idle_high: assert property (s_hi_wr ##0 (!timer_running && !reload_valid)
        |=> timer_count[15:8] == $past(sfr_wdata)) else $error("idle high load wrong");
    a_delta_halt: assert property (s_hi_wr ##0 (timer_running && {sfr_wdata, low_q} >= 16'h0004)
        |=> ##1 $stable(timer_count)) else $error("delta did not halt count");
    // Five held edges, then the count must move again once the delta is spent
    a_delta_resume: assert property (s_hi_wr ##0 (timer_running && {sfr_wdata, low_q} == 16'h0005)
        ##1 timer_running[*6] |=> $changed(timer_count)) else $error("count did not resume after delta");
endmodule
bind mtc_top mtc_chk u_chk (.clk_sys, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .ovf_cmp_event,
    .reload_valid, .irq_mask, .irq, .timer_count, .timer_running, .compare_pulse, .period_pulse);

// *** testbench/tb_top.sv ***
// Self-checking bench of the MAC timer configuration and value access block
`timescale 1ns/10ps
`include "mtc_regs.vh"
`define CHK(g, e) check_val(16'(g), 16'(e));
module tb_top;
    reg         clk_sys = 1'b0;
    reg         nrst = 1'b0;
    reg  [7:0]  sfr_addr = 8'h00;
    reg         sfr_wr = 1'b0;
    reg         sfr_rd = 1'b0;
    reg  [7:0]  sfr_wdata = 8'h00;
    reg         slow_clk = 1'b0;
    reg  [15:0] period = 16'h0000;
    reg         ovf_cmp_event = 1'b0;
    reg         reload_valid = 1'b0;
    reg  [15:0] reload_value = 16'h0000;
    reg  [2:0]  irq_mask = 3'h0;
    wire [7:0]  sfr_rdata;
    wire [15:0] timer_count;
    wire        irq;
    wire        timer_running;
    int         error_cnt = 0;
    int         cmp_count = 0;
    always #20 clk_sys = ~clk_sys;
    mtc_top dut (.clk_sys, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .slow_clk, .period,
        .ovf_cmp_event, .reload_valid, .reload_value, .irq_mask, .irq, .timer_count, .timer_running,
        .compare_pulse(), .period_pulse());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input [15:0] g, input [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One strobe cycle per access, idle cycle between, so no strobe is assigned twice at one edge
    task automatic wr(input [7:0] a, input [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        `CHK(sfr_rdata, e)
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; bit 2 is always written zero
    initial begin
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        rd(`MTC_ADDR_CONFIG, 8'h02);
        wr(`MTC_ADDR_CONFIG, 8'hF8);
        rd(`MTC_ADDR_CONFIG, 8'h08);
        rd(8'h55, 8'h00);
        wr(`MTC_ADDR_VALUE_LOW, 8'h77);
        `CHK(timer_count, 16'h0000)
        wr(`MTC_ADDR_VALUE_LOW, 8'h00);
        wr(`MTC_ADDR_VALUE_HIGH, 8'h12);
        `CHK(timer_count, 16'h1200)
        wr(`MTC_ADDR_COMPARE, 8'h20);
        wr(`MTC_ADDR_CONFIG, 8'h01);
        repeat (60) @(negedge clk_sys);
        wr(`MTC_ADDR_CONFIG, 8'h00);
        rd(`MTC_ADDR_CONFIG, 8'h00);
        wr(`MTC_ADDR_VALUE_HIGH, 8'h12);
        wr(`MTC_ADDR_CONFIG, 8'h09);
        repeat (60) @(negedge clk_sys);
        rd(`MTC_ADDR_CONFIG, 8'h89);
        `CHK(irq, 1'b0)
        irq_mask = 3'h4;
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        // Latched high byte must survive the count rolling past 0x1300
        wr(`MTC_ADDR_CONFIG, 8'h08);
        wr(`MTC_ADDR_VALUE_LOW, 8'hF0);
        wr(`MTC_ADDR_VALUE_HIGH, 8'h12);
        rd(`MTC_ADDR_VALUE_LOW, 8'hF0);
        wr(`MTC_ADDR_CONFIG, 8'h09);
        repeat (40) @(negedge clk_sys);
        rd(`MTC_ADDR_VALUE_HIGH, 8'h12);
        wr(`MTC_ADDR_VALUE_LOW, 8'h05);
        wr(`MTC_ADDR_VALUE_HIGH, 8'h00);
        repeat (8) @(negedge clk_sys);
        // All masks open so the period and overflow-compare requests are seen
        irq_mask = 3'h7;
        ovf_cmp_event = 1'b1;
        period = 16'h0001;
        @(negedge clk_sys);
        ovf_cmp_event = 1'b0;
        repeat (2) @(negedge clk_sys);
        period = 16'h0000;
        wr(`MTC_ADDR_CONFIG, 8'hE8);
        rd(`MTC_ADDR_CONFIG, 8'hE8);
        wr(`MTC_ADDR_CONFIG, 8'h08);
        rd(`MTC_ADDR_CONFIG, 8'h08);
        irq_mask = 3'h7;
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        // Aligned start and stop, paced by the slow tick
        wr(`MTC_ADDR_CONFIG, 8'h03);
        rd(`MTC_ADDR_CONFIG, 8'h02);
        slow_clk = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHK(timer_running, 1'b0)
        reload_value = 16'h4321;
        reload_valid = 1'b1;
        @(negedge clk_sys);
        reload_valid = 1'b0;
        `CHK(timer_count, 16'h4321)
        rd(`MTC_ADDR_CONFIG, 8'h03);
        wr(`MTC_ADDR_CONFIG, 8'h02);
        rd(`MTC_ADDR_CONFIG, 8'h03);
        slow_clk = 1'b0;
        repeat (3) @(negedge clk_sys);
        slow_clk = 1'b1;
        repeat (6) @(negedge clk_sys);
        rd(`MTC_ADDR_CONFIG, 8'h02);
        summarize();
    end
    // Watchdog well past the roughly 260 cycles the sequence needs
    initial begin
        #120000;
        error_cnt++;
        summarize();
    end
endmodule
